// >>> ccss_pkg.sv
// shared constants, types and factory tables for the camera configuration set store
package ccss_pkg;

  localparam int unsigned PARAM_WORDS    = 4;
  localparam int unsigned USER_SLOTS     = 3;
  localparam int unsigned LUT_DEPTH      = 16;
  localparam int unsigned LABEL_WORDS    = 2;

  // byte addresses of the 32-bit register words; the last two are upper-address tags of the active and lut pages
  localparam logic [7:0] OFS_COMMAND     = 8'h00;
  localparam logic [7:0] OFS_SLOT_SEL    = 8'h04;
  localparam logic [7:0] OFS_BOOT_SEL    = 8'h08;
  localparam logic [7:0] OFS_FACTORY_SEL = 8'h0C;
  localparam logic [7:0] OFS_STATUS      = 8'h10;
  localparam logic [7:0] OFS_LABEL_LO    = 8'h14;
  localparam logic [7:0] OFS_LABEL_HI    = 8'h18;
  localparam logic [7:0] OFS_VENDOR      = 8'h1C;
  localparam logic [7:0] OFS_MODEL       = 8'h20;
  localparam logic [7:0] OFS_MAKER_INFO  = 8'h24;
  localparam logic [7:0] OFS_HW_VERSION  = 8'h28;
  localparam logic [7:0] OFS_FW_VERSION  = 8'h2C;
  localparam logic [7:0] OFS_SERIAL      = 8'h30;
  localparam logic [7:0] OFS_SCAN_TYPE   = 8'h34;
  localparam logic [7:0] OFS_SENSOR_DIMS = 8'h38;
  localparam logic [7:0] OFS_ROI_LIMITS  = 8'h3C;
  localparam logic [3:0] OFS_ACTIVE_PAGE = 4'h4;
  localparam logic [1:0] OFS_LUT_PAGE    = 2'h2;

  // command and status bit positions
  localparam int unsigned CMD_STORE_BIT   = 0;
  localparam int unsigned CMD_RESTORE_BIT = 1;
  localparam int unsigned STS_REFUSED_BIT = 2;

  // selector codes: 0 is the default set, 1..3 the user slots
  localparam logic [1:0] SEL_DEFAULT     = 2'h0;
  localparam logic [1:0] SEL_RESET       = 2'h1;

  // active set word layout
  localparam logic [1:0] IDX_GAIN        = 2'h0;
  localparam logic [1:0] IDX_EXPOSURE    = 2'h1;
  localparam logic [1:0] IDX_AUTO        = 2'h2;
  localparam logic [1:0] IDX_BLACK       = 2'h3;

  localparam logic [15:0] GAIN_LOW       = 16'h0040;
  localparam logic [15:0] GAIN_6DB_DELTA = 16'h0040;
  localparam logic [15:0] GAIN_MIN       = 16'h0000;
  localparam logic [15:0] EXPOSURE_STD   = 16'h0BB8;
  localparam logic [15:0] EXPOSURE_COLOR = 16'h07D0;
  localparam logic [15:0] AUTO_NONE      = 16'h0000;
  localparam logic [15:0] AUTO_GAIN_CONT = 16'h0001;
  localparam logic [15:0] AUTO_EXP_CONT  = 16'h0002;
  localparam logic [15:0] BLACK_STD      = 16'h0020;
  localparam logic [15:0] BLACK_COLOR    = 16'h0010;
  localparam logic [15:0] WORD_ZERO      = 16'h0000;

  typedef enum logic [1:0] {
    CCSS_FS_STANDARD,
    CCSS_FS_HIGH_GAIN,
    CCSS_FS_AUTO,
    CCSS_FS_COLOR
  } ccss_factory_t;

  typedef logic [15:0]                    ccss_word_t;
  typedef ccss_word_t [PARAM_WORDS-1:0]   ccss_set_t;

  typedef struct packed {
    logic refused;
    logic boot_done;
    logic busy;
  } ccss_status_t;

  // factory setups are a constant table, so nothing can rewrite them
  function automatic ccss_set_t ccss_factory_set(input ccss_factory_t f);
    ccss_set_t s;
    s[IDX_GAIN]     = GAIN_LOW;
    s[IDX_EXPOSURE] = EXPOSURE_STD;
    s[IDX_AUTO]     = AUTO_NONE;
    s[IDX_BLACK]    = BLACK_STD;
    unique case (f)
      CCSS_FS_STANDARD: s[IDX_GAIN] = GAIN_LOW;
      CCSS_FS_HIGH_GAIN: s[IDX_GAIN] = GAIN_LOW + GAIN_6DB_DELTA;
      CCSS_FS_AUTO: begin
        s[IDX_GAIN] = GAIN_MIN;
        s[IDX_AUTO] = AUTO_GAIN_CONT | AUTO_EXP_CONT;
      end
      CCSS_FS_COLOR: begin
        s[IDX_EXPOSURE] = EXPOSURE_COLOR;
        s[IDX_BLACK]    = BLACK_COLOR;
      end
    endcase
    return s;
  endfunction

endpackage

// >>> ccss_top.sv
// configuration set store: active set, factory and user sets, device information
`timescale 1ns/1ps
module ccss_top
  import ccss_pkg::*;
#(
  parameter logic [31:0] VENDOR_ID     = 32'h0000_0001, // arbitrary value
  parameter logic [31:0] MODEL_ID      = 32'h0000_0002, // arbitrary value
  parameter logic [31:0] MAKER_INFO    = 32'h0000_0000, // arbitrary value
  parameter logic [31:0] HW_VERSION    = 32'h0000_0100, // arbitrary value
  parameter logic [31:0] FW_VERSION    = 32'h0000_0100, // arbitrary value
  parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0000, // arbitrary value
  parameter logic [31:0] SCAN_TYPE     = 32'h0000_0000, // arbitrary value
  parameter logic [15:0] SENSOR_COLS   = 16'h0280,
  parameter logic [15:0] SENSOR_ROWS   = 16'h01E0,
  parameter logic [15:0] ROI_W_LIMIT   = 16'h0280,
  parameter logic [15:0] ROI_H_LIMIT   = 16'h01E0
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         nv_init_n,
  input  wire logic         acq_active,
  input  wire logic [7:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  input  wire logic [3:0]   lut_addr,
  output logic [15:0]       lut_data,
  output ccss_set_t         active_set,
  output logic              busy
);

  typedef enum logic [1:0] {
    CCSS_BOOT,
    CCSS_IDLE,
    CCSS_LOAD,
    CCSS_SAVE
  } ccss_state_t;

  function automatic logic [31:0] ccss_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  localparam logic [1:0] LAST_IDX = 2'(PARAM_WORDS - 1);

  // volatile group
  ccss_state_t   state_q, state_d;
  logic [1:0]    idx_q, idx_d;
  logic [1:0]    src_q, src_d;
  logic [1:0]    slot_sel_q, slot_sel_d;
  ccss_set_t     active_q, active_d;
  ccss_word_t    lut_q [LUT_DEPTH];
  ccss_word_t    lut_d [LUT_DEPTH];
  ccss_word_t    lut_out_q, lut_out_d;
  logic          wait_q, wait_d;
  logic [31:0]   rdata_q, rdata_d;
  ccss_status_t  sts_q, sts_d;

  // non-volatile group, kept across reset_n
  ccss_set_t     slots_q [1:USER_SLOTS];
  ccss_set_t     slots_d [1:USER_SLOTS];
  logic [1:0]    boot_sel_q, boot_sel_d;
  ccss_factory_t fac_sel_q, fac_sel_d;
  logic [31:0]   label_q [LABEL_WORDS];
  logic [31:0]   label_d [LABEL_WORDS];

  logic          access;
  logic          in_active;
  logic          in_lut;
  logic          stall;
  logic          commit_wr;
  logic          store_req;
  logic          restore_req;
  logic          refuse;
  logic [31:0]   rd_mux;
  logic [31:0]   wr_word;
  ccss_word_t    src_word;
  ccss_set_t     def_set;

  always_comb begin
    access    = avs_read | avs_write;
    in_active = (avs_address[7:4] == OFS_ACTIVE_PAGE);
    in_lut    = (avs_address[7:6] == OFS_LUT_PAGE);
    // parameter writes wait out a copy so the copy owns the active set
    stall     = (state_q == CCSS_BOOT) ||
                (avs_write && in_active && (state_q != CCSS_IDLE));
    commit_wr = avs_write && !wait_q;
    def_set   = ccss_factory_set(fac_sel_q);

    rd_mux = 32'h0000_0000;
    if (in_active) begin
      rd_mux = {16'h0000, active_q[avs_address[3:2]]};
    end else if (in_lut) begin
      rd_mux = {16'h0000, lut_q[avs_address[5:2]]};
    end else begin
      unique case (avs_address)
        OFS_SLOT_SEL:    rd_mux = {30'h0000_0000, slot_sel_q};
        OFS_BOOT_SEL:    rd_mux = {30'h0000_0000, boot_sel_q};
        OFS_FACTORY_SEL: rd_mux = {30'h0000_0000, fac_sel_q};
        OFS_STATUS:      rd_mux = {29'h0000_0000, sts_q};
        OFS_LABEL_LO:    rd_mux = label_q[0];
        OFS_LABEL_HI:    rd_mux = label_q[1];
        OFS_VENDOR:      rd_mux = VENDOR_ID;
        OFS_MODEL:       rd_mux = MODEL_ID;
        OFS_MAKER_INFO:  rd_mux = MAKER_INFO;
        OFS_HW_VERSION:  rd_mux = HW_VERSION;
        OFS_FW_VERSION:  rd_mux = FW_VERSION;
        OFS_SERIAL:      rd_mux = SERIAL_NUMBER;
        OFS_SCAN_TYPE:   rd_mux = SCAN_TYPE;
        OFS_SENSOR_DIMS: rd_mux = {SENSOR_ROWS, SENSOR_COLS};
        OFS_ROI_LIMITS:  rd_mux = {ROI_H_LIMIT, ROI_W_LIMIT};
        default:         rd_mux = 32'h0000_0000;
      endcase
    end

    // selector 0 takes the default set, otherwise the user slot
    src_word = (src_q == SEL_DEFAULT) ? def_set[idx_q] : slots_q[src_q][idx_q];

    store_req   = commit_wr && (avs_address == OFS_COMMAND) &&
                  avs_byteenable[0] && avs_writedata[CMD_STORE_BIT];
    restore_req = commit_wr && (avs_address == OFS_COMMAND) &&
                  avs_byteenable[0] && avs_writedata[CMD_RESTORE_BIT];
  end

  always_comb begin
    state_d    = state_q;
    idx_d      = idx_q;
    src_d      = src_q;
    slot_sel_d = slot_sel_q;
    active_d   = active_q;
    lut_d      = lut_q;
    lut_out_d  = lut_q[lut_addr];
    rdata_d    = rdata_q;
    sts_d      = sts_q;
    slots_d    = slots_q;
    boot_sel_d = boot_sel_q;
    fac_sel_d  = fac_sel_q;
    label_d    = label_q;
    refuse     = 1'b0;
    wr_word    = 32'h0000_0000;

    // one wait cycle, then the answer; write lands on the answer edge
    wait_d = 1'b1;
    if (access && wait_q && !stall) begin
      wait_d  = 1'b0;
      rdata_d = rd_mux;
    end

    if (commit_wr) begin
      if (in_active) begin
        wr_word = ccss_merge({16'h0000, active_q[avs_address[3:2]]},
                             avs_writedata, avs_byteenable);
        active_d[avs_address[3:2]] = wr_word[15:0];
      end else if (in_lut) begin
        wr_word = ccss_merge({16'h0000, lut_q[avs_address[5:2]]},
                             avs_writedata, avs_byteenable);
        lut_d[avs_address[5:2]] = wr_word[15:0];
      end else begin
        unique case (avs_address)
          OFS_SLOT_SEL: begin
            if (avs_byteenable[0]) begin
              slot_sel_d = avs_writedata[1:0];
            end
          end
          OFS_BOOT_SEL: begin
            if (avs_byteenable[0]) begin
              boot_sel_d = avs_writedata[1:0];
            end
          end
          OFS_FACTORY_SEL: begin
            // changing the default set is held off during acquisition
            if (avs_byteenable[0] && !acq_active) begin
              fac_sel_d = ccss_factory_t'(avs_writedata[1:0]);
            end
          end
          OFS_STATUS: begin
            if (avs_byteenable[0] && avs_writedata[STS_REFUSED_BIT]) begin
              sts_d.refused = 1'b0;
            end
          end
          OFS_LABEL_LO: label_d[0] = ccss_merge(label_q[0], avs_writedata,
                                                avs_byteenable);
          OFS_LABEL_HI: label_d[1] = ccss_merge(label_q[1], avs_writedata,
                                                avs_byteenable);
          default: ;
        endcase
      end
    end

    unique case (state_q)
      CCSS_BOOT: begin
        src_d   = boot_sel_q;
        idx_d   = 2'h0;
        state_d = CCSS_LOAD;
      end
      CCSS_IDLE: begin
        if (store_req) begin
          if (slot_sel_q == SEL_DEFAULT) begin
            refuse = 1'b1;
          end else begin
            src_d   = slot_sel_q;
            idx_d   = 2'h0;
            state_d = CCSS_SAVE;
          end
        end else if (restore_req) begin
          if (acq_active) begin
            refuse = 1'b1;
          end else begin
            src_d   = slot_sel_q;
            idx_d   = 2'h0;
            state_d = CCSS_LOAD;
          end
        end
      end
      CCSS_LOAD: begin
        active_d[idx_q] = src_word;
        idx_d = idx_q + 2'h1;
        if (idx_q == LAST_IDX) begin
          state_d         = CCSS_IDLE;
          sts_d.boot_done = 1'b1;
        end
      end
      CCSS_SAVE: begin
        // every parameter word is rewritten; the table is never touched
        slots_d[src_q][idx_q] = active_q[idx_q];
        idx_d = idx_q + 2'h1;
        if (idx_q == LAST_IDX) begin
          state_d = CCSS_IDLE;
        end
      end
    endcase

    if ((state_q != CCSS_IDLE) && (store_req || restore_req)) begin
      refuse = 1'b1;
    end
    // a refusal in the same cycle as its clear is kept
    if (refuse) begin
      sts_d.refused = 1'b1;
    end
    sts_d.busy = (state_d != CCSS_IDLE);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= CCSS_BOOT;
      idx_q      <= 2'h0;
      src_q      <= SEL_DEFAULT;
      slot_sel_q <= SEL_RESET;
      active_q   <= '0;
      for (int i = 0; i < LUT_DEPTH; i++) begin
        lut_q[i] <= WORD_ZERO;
      end
      lut_out_q  <= WORD_ZERO;
      wait_q     <= 1'b1;
      rdata_q    <= 32'h0000_0000;
      sts_q      <= '{refused: 1'b0, boot_done: 1'b0, busy: 1'b1};
    end else begin
      state_q    <= state_d;
      idx_q      <= idx_d;
      src_q      <= src_d;
      slot_sel_q <= slot_sel_d;
      active_q   <= active_d;
      lut_q      <= lut_d;
      lut_out_q  <= lut_out_d;
      wait_q     <= wait_d;
      rdata_q    <= rdata_d;
      sts_q      <= sts_d;
    end
  end

  // stands in for flash: only the factory-programming init clears it
  always_ff @(posedge clk or negedge nv_init_n) begin
    if (!nv_init_n) begin
      for (int s = 1; s <= USER_SLOTS; s++) begin
        slots_q[s] <= '0;
      end
      boot_sel_q <= SEL_DEFAULT;
      fac_sel_q  <= CCSS_FS_STANDARD;
      for (int w = 0; w < LABEL_WORDS; w++) begin
        label_q[w] <= 32'h0000_0000;
      end
    end else begin
      slots_q    <= slots_d;
      boot_sel_q <= boot_sel_d;
      fac_sel_q  <= fac_sel_d;
      label_q    <= label_d;
    end
  end

  // factory contents come only from ccss_factory_set
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign lut_data        = lut_out_q;
  assign active_set      = active_q;
  assign busy            = sts_q.busy;

endmodule

// >>> ccss_monitor.sv
// port assertions for the configuration set store
`timescale 1ns/1ps
module ccss_monitor
  import ccss_pkg::*;
#(
  parameter logic [15:0] SENSOR_COLS = 16'h0280,
  parameter logic [15:0] SENSOR_ROWS = 16'h01E0,
  parameter logic [15:0] ROI_W_LIMIT = 16'h0280,
  parameter logic [15:0] ROI_H_LIMIT = 16'h01E0
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        nv_init_n,
  input wire logic        acq_active,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [3:0]  lut_addr,
  input wire logic [15:0] lut_data,
  input wire ccss_set_t   active_set,
  input wire logic        busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic rd_ok;
  logic rst_cmd;
  assign rd_ok = avs_read && !avs_waitrequest;
  // restore command taken while no copy runs
  assign rst_cmd = avs_write && !avs_waitrequest && avs_address == OFS_COMMAND && !busy &&
                   avs_byteenable[0] && avs_writedata[CMD_RESTORE_BIT] &&
                   !avs_writedata[CMD_STORE_BIT];
  chk_boot_busy: assert property ($rose(reset_n) |-> busy[*4] ##[1:3] !busy)
    else $error("boot copy busy window wrong");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_active_src: assert property ($changed(active_set) |->
    busy || $past(busy) || $past(avs_write && !avs_waitrequest))
    else $error("active set changed without write or copy");
  chk_sensor_dims: assert property (rd_ok && avs_address == OFS_SENSOR_DIMS |->
    avs_readdata == {SENSOR_ROWS, SENSOR_COLS})
    else $error("sensor size read wrong");
  chk_roi_limits: assert property (rd_ok && avs_address == OFS_ROI_LIMITS |->
    avs_readdata == {ROI_H_LIMIT, ROI_W_LIMIT})
    else $error("region limits read wrong");
  chk_restore_go: assert property (rst_cmd && !acq_active |-> ##[1:2] busy)
    else $error("restore did not start a copy");
  chk_restore_idle: assert property (rst_cmd && acq_active |=> !busy ##1 !busy)
    else $error("restore ran during acquisition");
  chk_busy_len: assert property ($rose(busy) |-> busy[*3] ##[1:4] !busy)
    else $error("copy busy length wrong");
endmodule

// >>> ccss_top_bench.sv
// self-checking bench for the configuration set store
`timescale 1ns/1ps
module ccss_top_bench;
  import ccss_pkg::*;
  localparam logic [31:0] ID_V = 32'h0000_5A5A; // arbitrary value
  // sizes differ from the defaults so a wired-in constant would show
  localparam logic [31:0] DIMS_V = 32'h0100_0200;
  localparam logic [31:0] ROI_V  = 32'h00C0_0180;
  logic        clk, reset_n, nv_init_n, acq_active, avs_read, avs_write, avs_waitrequest, busy;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, w, label;
  logic [3:0]  avs_byteenable, lut_addr;
  logic [15:0] lut_data, lv;
  ccss_set_t   active_set;
  logic [63:0] act;
  logic [63:0] slots [4];
  integer      fail_count, checks_done, seed, cycles, i, j, k;

  ccss_top #(.VENDOR_ID(ID_V), .SENSOR_COLS(DIMS_V[15:0]), .SENSOR_ROWS(DIMS_V[31:16]),
    .ROI_W_LIMIT(ROI_V[15:0]), .ROI_H_LIMIT(ROI_V[31:16])) ccss_top_inst (.clk(clk),
    .reset_n(reset_n),
    .nv_init_n(nv_init_n), .acq_active(acq_active), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lut_addr(lut_addr), .lut_data(lut_data),
    .active_set(active_set), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [63:0] fset(input integer f);
    case (f)
      1: return {BLACK_STD, AUTO_NONE, EXPOSURE_STD, GAIN_LOW + GAIN_6DB_DELTA};
      2: return {BLACK_STD, AUTO_GAIN_CONT | AUTO_EXP_CONT, EXPOSURE_STD, GAIN_MIN};
      3: return {BLACK_COLOR, AUTO_NONE, EXPOSURE_COLOR, GAIN_LOW};
      default: return {BLACK_STD, AUTO_NONE, EXPOSURE_STD, GAIN_LOW};
    endcase
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus cycle; always returns one edge after release
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_idle;
    repeat (2) @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      give_verdict;
    end
  end

  initial begin
    seed = 49;
    fail_count = 0;
    checks_done = 0;
    cycles = 0;
    reset_n = 1'b0;
    nv_init_n = 1'b0;
    acq_active = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    lut_addr = 4'h0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    nv_init_n <= 1'b1;
    wait_idle;
    check(active_set, fset(0));
    xfer(1'b1, OFS_VENDOR, ~ID_V);
    xfer(1'b0, OFS_VENDOR, 32'h0);
    check(q, ID_V);
    xfer(1'b0, OFS_SENSOR_DIMS, 32'h0);
    check(q, DIMS_V);
    xfer(1'b0, OFS_ROI_LIMITS, 32'h0);
    check(q, ROI_V);
    xfer(1'b0, 8'hF0, 32'h0);
    check(q, 32'h0);
    label = $random(seed);
    xfer(1'b1, OFS_LABEL_LO, label);
    xfer(1'b0, OFS_LABEL_LO, 32'h0);
    check(q, label);
    // only the two low lanes may land in the upper label word
    w = $random(seed);
    avs_byteenable <= 4'h3;
    xfer(1'b1, OFS_LABEL_HI, w);
    avs_byteenable <= 4'hF;
    xfer(1'b0, OFS_LABEL_HI, 32'h0);
    check(q, {16'h0000, w[15:0]});
    xfer(1'b1, OFS_SLOT_SEL, 32'h0);
    for (i = 0; i < 4; i++) begin
      xfer(1'b1, OFS_FACTORY_SEL, 32'(i));
      xfer(1'b1, OFS_COMMAND, 32'h0000_0002);
      wait_idle;
      check(active_set, fset(i));
    end
    acq_active <= 1'b1;
    xfer(1'b1, OFS_FACTORY_SEL, 32'h0);
    xfer(1'b0, OFS_FACTORY_SEL, 32'h0);
    check(q, 32'h3);
    xfer(1'b1, OFS_COMMAND, 32'h0000_0002);
    xfer(1'b0, OFS_STATUS, 32'h0);
    check(q, 32'h6);
    acq_active <= 1'b0;
    act = fset(3);
    lv = 16'($random(seed));
    xfer(1'b1, 8'h80, {16'h0000, lv});
    // slot 2 is stored twice so the second store must replace the first
    for (i = 0; i < 4; i++) begin
      k = (i == 3) ? 2 : i + 1;
      for (j = 0; j < 4; j++) begin
        w = $random(seed);
        xfer(1'b1, {OFS_ACTIVE_PAGE, j[1:0], 2'h0}, w);
        act[16*j +: 16] = w[15:0];
      end
      xfer(1'b0, {OFS_ACTIVE_PAGE, 2'h0, 2'h0}, 32'h0);
      check(q, {48'h0, act[15:0]});
      xfer(1'b1, OFS_SLOT_SEL, 32'(k));
      xfer(1'b1, OFS_COMMAND, 32'h0000_0001);
      wait_idle;
      slots[k] = act;
      check(active_set, act);
    end
    xfer(1'b1, OFS_STATUS, 32'h4);
    xfer(1'b1, OFS_SLOT_SEL, 32'h0);
    xfer(1'b1, OFS_COMMAND, 32'h0000_0001);
    xfer(1'b0, OFS_STATUS, 32'h0);
    check(q, 32'h6);
    xfer(1'b1, OFS_STATUS, 32'h4);
    xfer(1'b1, OFS_SLOT_SEL, 32'h1);
    xfer(1'b1, OFS_COMMAND, 32'h0000_0002);
    xfer(1'b1, OFS_COMMAND, 32'h0000_0001);
    wait_idle;
    xfer(1'b0, OFS_STATUS, 32'h0);
    check(q, 32'h6);
    for (k = 1; k < 4; k++) begin
      xfer(1'b1, OFS_SLOT_SEL, 32'(k));
      xfer(1'b1, OFS_COMMAND, 32'h0000_0002);
      wait_idle;
      check(active_set, slots[k]);
    end
    check(lut_data, lv);
    for (i = 0; i < 2; i++) begin
      xfer(1'b1, OFS_BOOT_SEL, (i == 0) ? 32'h2 : 32'h0);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      wait_idle;
      check(active_set, (i == 0) ? slots[2] : fset(3));
      check(lut_data, 16'h0000);
      xfer(1'b0, OFS_LABEL_LO, 32'h0);
      check(q, label);
    end
    give_verdict;
  end
endmodule

bind ccss_top ccss_monitor #(.SENSOR_COLS(SENSOR_COLS), .SENSOR_ROWS(SENSOR_ROWS),
  .ROI_W_LIMIT(ROI_W_LIMIT), .ROI_H_LIMIT(ROI_H_LIMIT)) ccss_monitor_inst (.clk(clk),
  .reset_n(reset_n), .nv_init_n(nv_init_n), .acq_active(acq_active),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lut_addr(lut_addr),
  .lut_data(lut_data), .active_set(active_set), .busy(busy));
